/* File: inc/ofe_pkg.sv */
// constants, operation codes and helper functions for the operand formatter
// assumes a 32-bit core datapath and a 32-bit word-wide memory bus
package ofe_pkg;

  // ==========================================================================
  // widths and sizes
  localparam int          DATA_W          = 32;
  localparam logic [1:0]  SZ_BYTE         = 2'h0;
  localparam logic [1:0]  SZ_WORD         = 2'h1;
  localparam logic [1:0]  SZ_LONG         = 2'h2;
  localparam logic [31:0] INSTR_STEP      = 32'h0000_0002; // 16-bit instruction
  localparam logic [31:0] LONG_ALIGN_MASK = 32'hffff_fffc;
  localparam logic [31:0] PC_RESET        = 32'h0000_0000;

  // on-chip device register window (arbitrary default decode)
  localparam logic [31:0] DEV_BASE_DEF    = 32'hff00_0000;
  localparam logic [31:0] DEV_MASK_DEF    = 32'hff00_0000;

  // ==========================================================================
  // operation codes presented by the decoder
  typedef enum logic [3:0] {
    MOVE_OP, ADD_OP, COMPARE_EQUAL_OP, TEST_AND_OP, AND_OP, OR_OP, XOR_OP,
    LOAD_OP, STORE_OP, LIT_WORD_OP, LIT_LONG_OP, BRANCH_OP, BRANCH_TRUE_OP,
    BRANCH_TRUE_SLOT_OP, AND_MEM_OP
  } ofe_op_e;

  // ==========================================================================
  // helpers
  function automatic logic [31:0] ofe_sext8(input logic [7:0] b);
    ofe_sext8 = {{24{b[7]}}, b};
  endfunction : ofe_sext8

  function automatic logic [31:0] ofe_sext16(input logic [15:0] h);
    ofe_sext16 = {{16{h[15]}}, h};
  endfunction : ofe_sext16

  function automatic logic [31:0] ofe_zext8(input logic [7:0] b);
    ofe_zext8 = {24'h00_0000, b};
  endfunction : ofe_zext8

  function automatic logic [15:0] ofe_swap16(input logic [15:0] h);
    ofe_swap16 = {h[7:0], h[15:8]};
  endfunction : ofe_swap16

  function automatic logic [31:0] ofe_swap32(input logic [31:0] w);
    ofe_swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : ofe_swap32

  // bytes never misalign; words need bit 0 clear, longwords bits 1:0
  function automatic logic ofe_misaligned(input logic [1:0] a, input logic [1:0] sz);
    ofe_misaligned = (sz == SZ_WORD) ? a[0] : (sz == SZ_LONG) ? (a != 2'h0) : 1'b0;
  endfunction : ofe_misaligned

endpackage : ofe_pkg

/* File: src/ofe_strap.sv */
// endian strap capture: samples the select pin while reset is held
// assumes the pin is steady for at least four clocks before reset release
`timescale 1ns/1ps
module ofe_strap
  import ofe_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // strap pin
  input  wire logic endian_select_pin,
  // captured mode
  output logic      little_endian,
  output logic      mode_ok
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================================
  // three-stage synchroniser, free running so it works during reset
  always_ff @(posedge ref_clk) begin
    s1_q <= endian_select_pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // capture only while reset is low; frozen afterwards until next reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_ok <= 1'b0;
      if (s2_q == s3_q) begin
        little_endian <= s3_q; // RL7
      end
    end else begin
      mode_ok <= 1'b1; // RL8
    end
  end

endmodule : ofe_strap

/* File: src/ofe_lane.sv */
// byte-lane steering between a register value and a 32-bit memory word
// assumes lane k of the bus carries the byte at word address plus k
`timescale 1ns/1ps
module ofe_lane
  import ofe_pkg::*;
(
  // access shape
  input  wire logic        big_endian,
  input  wire logic [1:0]  size,
  input  wire logic [1:0]  offs,
  // store side
  input  wire logic [31:0] wr_data,
  output logic      [31:0] wr_word,
  output logic      [3:0]  wr_be,
  // load side
  input  wire logic [31:0] rd_word,
  output logic      [31:0] ld_value
);

  logic [15:0] rd_half;
  logic [7:0]  rd_byte;

  // ==========================================================================
  // store: replicate the operand over the lanes, enables pick the bytes
  always_comb begin
    wr_word = big_endian ? ofe_swap32(wr_data) : wr_data; // RL4 RL5
    wr_be   = 4'hf;
    if (size == SZ_BYTE) begin
      wr_word = {4{wr_data[7:0]}};
      wr_be   = 4'h1 << offs;
    end else if (size == SZ_WORD) begin
      wr_word = {2{big_endian ? ofe_swap16(wr_data[15:0]) : wr_data[15:0]}};
      wr_be   = offs[1] ? 4'hc : 4'h3;
    end
  end

  // load: extract, reorder and sign-extend to a full longword
  always_comb begin
    rd_half  = offs[1] ? rd_word[31:16] : rd_word[15:0];
    rd_byte  = offs[1] ? (offs[0] ? rd_word[31:24] : rd_word[23:16])
                       : (offs[0] ? rd_word[15:8] : rd_word[7:0]);
    ld_value = big_endian ? ofe_swap32(rd_word) : rd_word; // RL1
    if (size == SZ_BYTE) begin
      ld_value = ofe_sext8(rd_byte); // RL2
    end else if (size == SZ_WORD) begin
      ld_value = ofe_sext16(big_endian ? ofe_swap16(rd_half) : rd_half); // RL2
    end
  end

endmodule : ofe_lane

/* File: src/ofe_core_fmt.sv */
// operand formatting, alignment checking and instruction sequencing
// assumes one memory access outstanding and a decoder feeding operations
//
// Overview of operation
// (RL1) register operands are always full 32-bit longwords
// (RL2) byte and word loads are sign-extended
// (RL3) misaligned word or longword raises address error
// (RL4) big-endian: register MSB at lowest address
// (RL5) little-endian: register MSB at highest address
// (RL6) device registers always use big-endian ordering
// (RL7) endian mode comes from pin during reset
// (RL8) endian mode stays fixed until next reset
// (RL9) big-endian instruction: upper byte at lower address
// (RL10) little-endian instruction: lower byte at lower address
// (RL11) fixed 16-bit instructions, one step each
// (RL12) arithmetic immediates sign-extend, logical ones zero-extend
// (RL13) unconditional branch runs its slot instruction first
// (RL14) compares set flag, branches test it, add doesn't
// (RL15) byte literals inline, wider ones pc-relative table
// (RL16) register-only ops, but memory and-op acts in place
// (RL17) byte accesses never raise address error
`timescale 1ns/1ps
module ofe_core_fmt
  import ofe_pkg::*;
#(
  parameter logic [31:0] DEV_BASE = DEV_BASE_DEF,
  parameter logic [31:0] DEV_MASK = DEV_MASK_DEF
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // endian strap
  input  wire logic        endian_select_pin,
  // instruction fetch
  input  wire logic        fetch_valid,
  input  wire logic [31:0] fetch_pc,
  input  wire logic [31:0] fetch_word,
  output logic             instr_valid,
  output logic      [15:0] instr_word,
  output logic             fetch_err,
  // operation request
  input  wire logic        op_valid,
  input  wire logic [3:0]  op_kind,
  input  wire logic [1:0]  op_size,
  input  wire logic [31:0] op_addr,
  input  wire logic [31:0] op_src,
  input  wire logic [7:0]  op_imm,
  input  wire logic [31:0] op_target,
  output logic             op_ready,
  // results and status
  output logic             res_valid,
  output logic      [31:0] res_data,
  output logic             psw_compare_flag,
  output logic             addr_err,
  output logic      [31:0] pc,
  output logic             little_endian,
  // memory bus
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [3:0]  mem_be,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_done,
  input  wire logic [31:0] mem_rdata
);

  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_RMW, ST_WR} ofe_state_e;

  ofe_state_e  state_q, state_d;
  ofe_op_e     kind;
  logic        mode_ok;
  logic        op_fire;
  logic        is_mem;
  logic        mis;
  logic        dev_hit;
  logic [31:0] eff_addr;
  logic [1:0]  eff_size;
  logic        lane_big;
  logic [1:0]  lane_size;
  logic [1:0]  lane_offs;
  logic [31:0] lane_wdata;
  logic [31:0] lane_wword;
  logic [3:0]  lane_be;
  logic [31:0] ld_value;
  logic [1:0]  cur_size_q;
  logic [1:0]  cur_offs_q;
  logic        cur_big_q;
  logic [7:0]  cur_imm_q;
  logic        pend_q;
  logic [31:0] pend_tgt_q;
  logic        res_byte_q;
  logic [15:0] fetch_half;

  // ==========================================================================
  // endian strap and lane steering
  ofe_strap u_strap (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .endian_select_pin (endian_select_pin),
    .little_endian     (little_endian),
    .mode_ok           (mode_ok)
  );

  ofe_lane u_lane (
    .big_endian (lane_big),
    .size       (lane_size),
    .offs       (lane_offs),
    .wr_data    (lane_wdata),
    .wr_word    (lane_wword),
    .wr_be      (lane_be),
    .rd_word    (mem_rdata),
    .ld_value   (ld_value)
  );

  // ==========================================================================
  // request decode
  assign kind    = ofe_op_e'(op_kind);
  assign op_fire = op_valid && op_ready;
  assign is_mem  = (kind == LOAD_OP) || (kind == STORE_OP) || (kind == LIT_WORD_OP)
                || (kind == LIT_LONG_OP) || (kind == AND_MEM_OP); // RL16

  // effective address and size; literal tables sit pc-relative
  always_comb begin
    eff_addr = op_addr;
    eff_size = op_size;
    case (kind)
      LIT_WORD_OP: begin
        eff_addr = pc + {23'h00_0000, op_imm, 1'b0}; // RL15
        eff_size = SZ_WORD;
      end
      LIT_LONG_OP: begin
        eff_addr = (pc & LONG_ALIGN_MASK) + {22'h00_0000, op_imm, 2'b00}; // RL15
        eff_size = SZ_LONG;
      end
      AND_MEM_OP: eff_size = SZ_BYTE; // RL16
      default:    eff_size = op_size;
    endcase
  end

  assign mis     = ofe_misaligned(eff_addr[1:0], eff_size); // RL3 RL17
  assign dev_hit = (eff_addr & DEV_MASK) == DEV_BASE;

  // lane shape comes from the request when idle, else from the held access
  always_comb begin
    if (state_q == ST_IDLE) begin
      lane_big  = !little_endian || dev_hit; // RL6
      lane_size = eff_size;
      lane_offs = eff_addr[1:0];
    end else begin
      lane_big  = cur_big_q;
      lane_size = cur_size_q;
      lane_offs = cur_offs_q;
    end
    // read-modify-write writes back the loaded byte anded with the immediate
    lane_wdata = (state_q == ST_RMW) ? {24'h00_0000, ld_value[7:0] & cur_imm_q} : op_src;
  end

  // ==========================================================================
  // access sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (op_fire && is_mem && !mis) begin
          if (kind == STORE_OP) begin
            state_d = ST_WR;
          end else if (kind == AND_MEM_OP) begin
            state_d = ST_RMW;
          end else begin
            state_d = ST_RD;
          end
        end
      end
      ST_RD:   if (mem_done) state_d = ST_IDLE;
      ST_RMW:  if (mem_done) state_d = ST_WR;
      ST_WR:   if (mem_done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // state and ready; ready waits for a captured endian mode
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      op_ready <= 1'b0;
    end else begin
      state_q  <= state_d;
      op_ready <= mode_ok && (state_d == ST_IDLE);
    end
  end

  // held access shape for the response and the write-back
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_size_q <= SZ_BYTE;
      cur_offs_q <= 2'h0;
      cur_big_q  <= 1'b1;
      cur_imm_q  <= 8'h00;
    end else if (op_fire) begin
      cur_size_q <= eff_size;
      cur_offs_q <= eff_addr[1:0];
      cur_big_q  <= lane_big;
      cur_imm_q  <= op_imm;
    end
  end

  // memory request: one-cycle strobe, address and data held until next one
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_be    <= 4'h0;
      mem_wdata <= 32'h0000_0000;
    end else begin
      mem_req <= 1'b0;
      if (op_fire && is_mem && !mis) begin
        mem_req   <= 1'b1; // RL17
        mem_we    <= (kind == STORE_OP);
        mem_addr  <= {eff_addr[31:2], 2'b00};
        mem_be    <= lane_be;
        mem_wdata <= lane_wword; // RL4 RL5 RL6
      end else if ((state_q == ST_RMW) && mem_done) begin
        mem_req   <= 1'b1; // RL16
        mem_we    <= 1'b1;
        mem_be    <= lane_be;
        mem_wdata <= lane_wword;
      end
    end
  end

  // ==========================================================================
  // register results; every result is a full longword
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      res_valid  <= 1'b0;
      res_data   <= 32'h0000_0000;
      res_byte_q <= 1'b0;
      addr_err   <= 1'b0;
    end else begin
      res_valid <= 1'b0;
      addr_err  <= 1'b0;
      if (op_fire) begin
        res_byte_q <= 1'b0;
        case (kind)
          MOVE_OP: begin
            res_valid <= 1'b1;
            res_data  <= ofe_sext8(op_imm); // RL12 RL15
          end
          ADD_OP: begin
            res_valid <= 1'b1;
            res_data  <= op_src + ofe_sext8(op_imm); // RL12
          end
          AND_OP: begin
            res_valid <= 1'b1;
            res_data  <= op_src & ofe_zext8(op_imm); // RL12
          end
          OR_OP: begin
            res_valid <= 1'b1;
            res_data  <= op_src | ofe_zext8(op_imm); // RL12
          end
          XOR_OP: begin
            res_valid <= 1'b1;
            res_data  <= op_src ^ ofe_zext8(op_imm); // RL12
          end
          default: addr_err <= is_mem && mis; // RL3
        endcase
      end else if ((state_q == ST_RD) && mem_done) begin
        res_valid  <= 1'b1;
        res_data   <= ld_value; // RL1 RL2
        res_byte_q <= (cur_size_q == SZ_BYTE);
      end
    end
  end

  // compare flag; only compare and test write it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      psw_compare_flag <= 1'b0;
    end else if (op_fire && (kind == COMPARE_EQUAL_OP)) begin
      psw_compare_flag <= (op_src == ofe_sext8(op_imm)); // RL12 RL14
    end else if (op_fire && (kind == TEST_AND_OP)) begin
      psw_compare_flag <= ((op_src & ofe_zext8(op_imm)) == 32'h0000_0000); // RL12 RL14
    end
  end

  // ==========================================================================
  // program counter with delayed branching
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pc         <= PC_RESET;
      pend_q     <= 1'b0;
      pend_tgt_q <= 32'h0000_0000;
    end else if (op_fire) begin
      if (pend_q) begin
        // slot done; a branch placed in the slot is not honoured
        pc     <= pend_tgt_q; // RL13
        pend_q <= 1'b0;
      end else begin
        pc <= pc + INSTR_STEP; // RL11
        case (kind)
          BRANCH_OP: begin
            pend_q     <= 1'b1; // RL13
            pend_tgt_q <= op_target;
          end
          BRANCH_TRUE_OP: begin
            if (psw_compare_flag) pc <= op_target; // RL14
          end
          BRANCH_TRUE_SLOT_OP: begin
            pend_q     <= psw_compare_flag; // RL14
            pend_tgt_q <= op_target;
          end
          default: pend_q <= 1'b0;
        endcase
      end
    end
  end

  // instruction word assembly from the fetched memory word
  assign fetch_half = fetch_pc[1] ? fetch_word[31:16] : fetch_word[15:0];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      instr_valid <= 1'b0;
      instr_word  <= 16'h0000;
      fetch_err   <= 1'b0;
    end else begin
      instr_valid <= fetch_valid && !fetch_pc[0]; // RL11
      fetch_err   <= fetch_valid && fetch_pc[0];
      // lane order means big-endian needs the swap, little-endian not
      instr_word  <= little_endian ? fetch_half : ofe_swap16(fetch_half); // RL9 RL10
    end
  end

  // ==========================================================================
  // checks
  sequence rmw_start_s;
    op_fire && (kind == AND_MEM_OP);
  endsequence

  sequence rmw_read_s;
    mem_req && !mem_we && (state_q == ST_RMW);
  endsequence

  sign_ext_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL2
    res_valid && res_byte_q |-> (res_data[31:7] == 25'h0 || res_data[31:7] == 25'h1ffffff))
    else $error("byte load not sign-extended");

  misalign_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL3
    op_fire && (kind == LOAD_OP) && (op_size == SZ_WORD) && op_addr[0]
    |=> addr_err && !mem_req)
    else $error("odd word access missed address error");

  byte_any_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL17
    op_fire && (kind == LOAD_OP) && (op_size == SZ_BYTE) |=> mem_req && !addr_err)
    else $error("byte access refused");

  endian_fixed_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL8
    $past(rst_n) |-> $stable(little_endian))
    else $error("endian mode changed after reset");

  big_long_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL4
    op_fire && (kind == STORE_OP) && (op_size == SZ_LONG) && !little_endian && !mis
    |=> mem_req && mem_wdata == ofe_swap32($past(op_src)))
    else $error("big-endian longword lanes wrong");

  little_long_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL5
    op_fire && (kind == STORE_OP) && (op_size == SZ_LONG) && little_endian && !dev_hit && !mis
    |=> mem_req && mem_wdata == $past(op_src))
    else $error("little-endian longword lanes wrong");

  dev_big_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL6
    op_fire && (kind == STORE_OP) && (op_size == SZ_LONG) && dev_hit && !mis
    |=> mem_req && mem_wdata == ofe_swap32($past(op_src)))
    else $error("device register not big-endian");

  slot_jump_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL13
    op_fire && !pend_q && (kind == BRANCH_OP)
    |=> pend_q && (pc == $past(pc) + INSTR_STEP))
    else $error("branch did not defer to slot");

  slot_done_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL13
    op_fire && pend_q |=> !pend_q && (pc == $past(pend_tgt_q)))
    else $error("slot did not hand over to target");

  add_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL14
    op_fire && (kind == ADD_OP) |=> $stable(psw_compare_flag))
    else $error("add changed compare flag");

  zext_logic_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL12
    op_fire && kind == OR_OP |=> res_valid && res_data == ($past(op_src) | {24'h0, $past(op_imm)}))
    else $error("logical immediate not zero-extended");

  rmw_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL16
    rmw_start_s ##1 rmw_read_s ##[2:5] (mem_done && (state_q == ST_RMW)) |=> mem_req && mem_we)
    else $error("memory and-op did not write back");

endmodule : ofe_core_fmt

/* File: tb/ofe_mem_model.sv */
// memory partner: 64-word array answering one request at a time
// assumes lane k of the bus is the byte at word address plus k
`timescale 1ns/1ps
module ofe_mem_model (
  // clock
  input  wire logic        ref_clk,
  // memory bus
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_done = 1'h0,
  output logic      [31:0] mem_rdata = 32'h0
);
  logic [31:0] mem_q [64];
  logic [31:0] last_q = 32'h0;
  logic        busy_q = 1'h0;
  int          wait_q = 0;

  // ==========================================
  // reply after 1..4 idle cycles; data is scrambled when no reply stands
  always @(posedge ref_clk) begin
    mem_done <= 1'h0;
    mem_rdata <= ~last_q;
    if (mem_req) begin
      busy_q <= 1'h1;
      wait_q <= $urandom_range(0, 3);
    end else if (busy_q && wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (busy_q) begin
      busy_q <= 1'h0;
      mem_done <= 1'h1;
      mem_rdata <= mem_q[mem_addr[7:2]];
      last_q <= mem_q[mem_addr[7:2]];
      // byte enables make read-modify-write of one lane possible
      for (int k = 0; k < 4; k++) begin
        if (mem_we && mem_be[k]) mem_q[mem_addr[7:2]][8*k +: 8] <= mem_wdata[8*k +: 8];
      end
    end
  end
endmodule : ofe_mem_model

/* File: tb/tb_cpu_operand_format_and_endian.sv */
// bench for the operand formatter: lanes, loads, alignment, fetch, alu, branch
// assumes ofe_mem_model on the memory bus and default device window
`timescale 1ns/1ps
module tb_cpu_operand_format_and_endian
  import ofe_pkg::*;
;
  // ==========================================
  // stimulus and observed signals
  logic        ref_clk = 1'h0, rst_n = 1'h0, endian_select_pin = 1'h0;
  logic        fetch_valid = 1'h0, op_valid = 1'h0;
  logic [31:0] fetch_pc = 32'h0, fetch_word = 32'h0, op_addr = 32'h0;
  logic [31:0] op_src = 32'h0, op_target = 32'h0;
  logic [3:0]  op_kind = 4'h0;
  logic [1:0]  op_size = 2'h0;
  logic [7:0]  op_imm = 8'h0;
  logic        instr_valid, fetch_err, op_ready, res_valid, psw_compare_flag;
  logic        addr_err, little_endian, mem_req, mem_we, mem_done, got_err;
  logic [15:0] instr_word;
  logic [31:0] res_data, pc, mem_addr, mem_wdata, mem_rdata, got_res, got_wd;
  logic [3:0]  mem_be, got_be;
  int          n_fail = 0, tests_run = 0, cyc = 0;

  ofe_core_fmt ofe_core_fmt_i (
    .ref_clk, .rst_n, .endian_select_pin, .fetch_valid, .fetch_pc, .fetch_word,
    .instr_valid, .instr_word, .fetch_err, .op_valid, .op_kind, .op_size, .op_addr,
    .op_src, .op_imm, .op_target, .op_ready, .res_valid, .res_data, .psw_compare_flag,
    .addr_err, .pc, .little_endian, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata,
    .mem_done, .mem_rdata
  );
  ofe_mem_model ofe_mem_model_i (
    .ref_clk, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_done, .mem_rdata
  );

  // ==========================================
  // clock and hang guard
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ==========================================
  // expectations: byte k of a longword stored at an aligned base
  function automatic logic [7:0] byt(logic [31:0] v, logic le, int k);
    byt = le ? v[8*k +: 8] : v[8*(3-k) +: 8];
  endfunction : byt

  function automatic logic [31:0] ld_exp(logic [31:0] v, logic le, logic [1:0] sz, int o);
    logic [7:0] b0;
    logic [7:0] b1;
    b0 = byt(v, le, o);
    b1 = byt(v, le, (o + 1) & 3);
    if (sz == SZ_BYTE) ld_exp = {{24{b0[7]}}, b0};
    else if (le) ld_exp = {{16{b1[7]}}, b1, b0};
    else ld_exp = {{16{b0[7]}}, b0, b1};
  endfunction : ld_exp

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // one request held until taken, then outcome collected until ready returns
  task automatic op(ofe_op_e k, logic [1:0] sz, logic [31:0] a, s, logic [7:0] im);
    int n;
    @(posedge ref_clk);
    op_valid <= 1'h1;
    op_kind <= k;
    op_size <= sz;
    op_addr <= a;
    op_target <= a;
    op_src <= s;
    op_imm <= im;
    n = 0;
    do @(negedge ref_clk); while (op_ready !== 1'h1 && n++ < 50);
    @(posedge ref_clk);
    op_valid <= 1'h0;
    got_res = 32'hx;
    got_err = 1'h0;
    for (n = 0; n < 60; n++) begin
      @(negedge ref_clk);
      if (res_valid === 1'h1) got_res = res_data;
      if (addr_err === 1'h1) got_err = 1'h1;
      if (mem_req === 1'h1) got_wd = mem_wdata;
      if (mem_req === 1'h1) got_be = mem_be;
      if (n > 0 && op_ready === 1'h1) break;
    end
  endtask : op

  // ==========================================
  // main sequence: big mode, then a second reset into little mode
  initial begin
    logic [31:0] v, a, e, se, ze;
    logic [7:0]  im, b;
    logic        m, le, fl;
    ofe_op_e     k;
    void'($urandom(51));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    for (int md = 0; md < 2; md++) begin
      if (md == 1) begin
        @(posedge ref_clk);
        rst_n <= 1'h0;
        endian_select_pin <= 1'h1;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'h1;
      end
      repeat (3) @(posedge ref_clk);
      m = md[0];
      fl = 1'h0;
      chk("mode", m, little_endian);
      endian_select_pin <= ~m; // pin moves after reset; mode must not
      // stores and loads; last two rounds hit the device window
      for (int i = 0; i < 6; i++) begin
        v = (i == 0) ? 32'h80ff_7f01 : $urandom;
        a = 32'($urandom_range(0, 63)) << 2;
        if (i >= 4) a = a | DEV_BASE_DEF;
        le = m && i < 4;
        op(STORE_OP, SZ_LONG, a, v, 8'h0);
        for (int j = 0; j < 4; j++) chk("lane", byt(v, le, j), got_wd[8*j +: 8]);
        chk("be", 4'hf, got_be);
        op(LOAD_OP, SZ_LONG, a, 32'h0, 8'h0);
        chk("ld_long", v, got_res);
        for (int o = 0; o < 4; o++) begin
          op(LOAD_OP, SZ_BYTE, a + o, 32'h0, 8'h0);
          chk("ld_byte", ld_exp(v, le, SZ_BYTE, o), got_res);
          chk("byte_err", 1'h0, got_err);
        end
        for (int o = 0; o < 4; o += 2) begin
          op(LOAD_OP, SZ_WORD, a + o, 32'h0, 8'h0);
          chk("ld_word", ld_exp(v, le, SZ_WORD, o), got_res);
        end
        op(LOAD_OP, SZ_WORD, a + 1, 32'h0, 8'h0);
        chk("word_err", 1'h1, got_err);
        op(STORE_OP, SZ_LONG, a + 2, v, 8'h0);
        chk("long_err", 1'h1, got_err);
        im = $urandom;
        b = byt(v, le, 3) & im;
        op(AND_MEM_OP, SZ_BYTE, a + 3, 32'h0, im);
        op(LOAD_OP, SZ_BYTE, a + 3, 32'h0, 8'h0);
        chk("and_mem", {{24{b[7]}}, b}, got_res);
      end
      chk("mode_hold", m, little_endian);
      // instruction fetch, odd pcs among them
      for (int i = 0; i < 8; i++) begin
        v = $urandom;
        a = $urandom & 32'h0000_00ff;
        @(posedge ref_clk);
        fetch_valid <= 1'h1;
        fetch_pc <= a;
        fetch_word <= v;
        @(posedge ref_clk);
        fetch_valid <= 1'h0;
        @(negedge ref_clk);
        e = a[1] ? v[31:16] : v[15:0];
        if (!m) e = {16'h0, e[7:0], e[15:8]};
        chk("fetch_err", a[0], fetch_err);
        chk("instr_valid", !a[0], instr_valid);
        if (!a[0]) chk("instr", e[15:0], instr_word);
      end
      // immediates and the compare flag, second pass forces true results
      for (int i = 0; i < 14; i++) begin
        im = $urandom;
        se = {{24{im[7]}}, im};
        ze = {24'h0, im};
        k = ofe_op_e'(i % 7);
        v = (i < 7) ? $urandom : (k == COMPARE_EQUAL_OP) ? se : ~ze;
        op(k, SZ_LONG, 32'h0, v, im);
        case (k)
          MOVE_OP: e = se;
          ADD_OP: e = v + se;
          AND_OP: e = v & ze;
          OR_OP: e = v | ze;
          default: e = v ^ ze;
        endcase
        if (k == COMPARE_EQUAL_OP) fl = (v == se);
        if (k == TEST_AND_OP) fl = ((v & ze) == 32'h0);
        chk("flag", fl, psw_compare_flag);
        if (k != COMPARE_EQUAL_OP && k != TEST_AND_OP) chk("alu", e, got_res);
      end
      // delayed branch then conditional branch on the flag
      e = pc + INSTR_STEP;
      op(BRANCH_OP, SZ_LONG, 32'h0000_0100, 32'h0, 8'h0);
      chk("pc_slot", e, pc);
      op(MOVE_OP, SZ_LONG, 32'h0, 32'h0, 8'h05);
      chk("slot_res", 32'h5, got_res);
      chk("pc_tgt", 32'h0000_0100, pc);
      if (md == 1) begin
        op(COMPARE_EQUAL_OP, SZ_LONG, 32'h0, 32'h1, 8'h0);
        fl = 1'h0;
      end
      e = fl ? 32'h0000_0040 : pc + INSTR_STEP;
      op(md ? BRANCH_TRUE_SLOT_OP : BRANCH_TRUE_OP, SZ_LONG, 32'h0000_0040, 32'h0, 8'h0);
      chk("pc_bt", e, pc);
      // longword and word literals from a pc-relative table
      im = $urandom_range(0, 15);
      v = $urandom;
      a = ((pc + INSTR_STEP) & LONG_ALIGN_MASK) + {im, 2'h0};
      op(STORE_OP, SZ_LONG, a, v, 8'h0);
      op(LIT_LONG_OP, SZ_LONG, 32'h0, 32'h0, im);
      chk("lit_long", v, got_res);
      a = pc + INSTR_STEP + {im, 1'b0};
      op(STORE_OP, SZ_WORD, a, v, 8'h0);
      op(LIT_WORD_OP, SZ_WORD, 32'h0, 32'h0, im);
      chk("lit_word", {{16{v[15]}}, v[15:0]}, got_res);
    end
    print_verdict();
  end
endmodule : tb_cpu_operand_format_and_endian
